// ===== design/arc_ctrl.sv
// Auto-retransmit and acknowledgement controller with its registers.
// Assumes an SPI decoder delivering register accesses and payload-write commands,
// and a baseband that sends packets, receives them and reports acknowledgements.
`timescale 1ns/1ps

// How it works
// - With auto-retransmit on, an unacknowledged packet is sent again.
// - Eight per-pipe enable bits, bit 0 pipe 1, reset to zero.
// - Wait window is (upper timing nibble + 1) times 250 us.
// - Wait window starts when the packet finishes going on air.
// - On window expiry without acknowledgement, receive mode ends at once.
// - After the window, idle for the resend gap, then resend.
// - Gap multiplier runs 1, 2, 3, then restarts at 1.
// - Upper nibble of resend register holds resend limit, read-write, reset zero.
// - Lower nibble is read-only resend tally, reset zero.
// - Payload command starts transmit synthesizer; 130 us settle before air.
// - Airtime is total packet bits over data rate.
// - Receive synthesizer starts on mode pin or control bit 7; 130 us settle.
// - Receive interrupt follows a received packet with no negative delay.
// - Arrival of the acknowledgement raises the success interrupt.
// - Packet stays buffered until acknowledged or resending ends.
// - Repeat packet with same identifier and CRC is acknowledged, no interrupt.
module arc_ctrl #(
	parameter int ACK_STEP_CYC = arc_pkg::ACK_STEP_CYC,
	parameter int PLL_CYC      = arc_pkg::PLL_CYC,
	parameter int GAP_STEP_CYC = arc_pkg::GAP_STEP_CYC
) (
	// Clock and reset
	input  wire logic                 I_CLK,
	input  wire logic                 I_RST_B,
	// Register access from the SPI decoder
	input  wire arc_pkg::arc_reg_req_s I_REG,
	output logic [7:0]                O_REG_RDATA,
	// Transmit payload command
	input  wire logic                 I_TX_CMD,
	input  wire logic [3:0]           I_TX_PIPE,
	input  wire logic [7:0]           I_TX_FIRST_BYTE,
	// Baseband transmit side
	output logic                      O_TX_PLL_ON,
	output logic                      O_TX_START,
	input  wire logic                 I_TX_DONE,
	output logic                      O_TX_HOLD,
	// Baseband receive side
	input  wire logic                 I_MODE,
	output logic                      O_RX_PLL_ON,
	output logic                      O_RX_READY,
	input  wire logic                 I_ACK_OK,
	input  wire logic                 I_RX_VALID,
	input  wire arc_pkg::arc_rx_pkt_s I_RX_PKT,
	output logic                      O_ACK_SEND,
	// Events to the host
	output logic                      O_TX_OK,
	output logic                      O_TX_FAIL,
	output logic                      O_RX_IRQ
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	arc_pkg::arc_state_e st, next_st;
	logic [7:0]  pipe_auto_ack_enable, next_pipe_auto_ack_enable;
	logic [7:0]  ack_wait_and_resend_delay, next_ack_wait_and_resend_delay;
	logic [3:0]  resend_limit, next_resend_limit;
	logic [3:0]  resend_tally, next_resend_tally;
	logic        rx_ctrl_on, next_rx_ctrl_on;
	logic [1:0]  mult, next_mult;
	logic        auto_mode, next_auto_mode;
	logic [2:0]  last_pid, next_last_pid;
	logic [15:0] last_crc, next_last_crc;
	logic        last_seen, next_last_seen;
	logic [31:0] rx_settle, next_rx_settle;
	logic [7:0]  next_rdata;
	logic        next_tx_start, next_tx_ok, next_tx_fail, next_rx_irq, next_ack_send;
	logic        next_rx_pll_on, next_rx_ready;
	logic        tm_load;
	logic [31:0] tm_count;
	logic        tm_done;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic pipe_enabled(input logic [7:0] en, input logic [3:0] pipe);
		logic r;
		r = 1'b0;
		if (pipe >= 4'h1 && pipe <= 4'h8) begin
			r = en[3'(pipe - 4'h1)];
		end
		return r;
	endfunction : pipe_enabled

	function automatic logic [31:0] cyc(input logic [3:0] n, input int step);
		return 32'(n) * 32'(step);
	endfunction : cyc

	logic [3:0] wait_field;
	logic [3:0] gap_field;
	assign wait_field = ack_wait_and_resend_delay[arc_pkg::WAIT_MSB:arc_pkg::WAIT_LSB];
	assign gap_field  = ack_wait_and_resend_delay[arc_pkg::GAP_MSB:arc_pkg::GAP_LSB];

	arc_timer #(
		.W (32)
	) u_timer (
		.i_clk   (I_CLK),
		.i_rst_b (I_RST_B),
		.i_load  (tm_load),
		.i_count (tm_count),
		.i_stop  (I_ACK_OK && st == arc_pkg::ST_ACK_WAIT),
		.o_done  (tm_done)
	);

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	always_comb begin
		next_st                        = st;
		next_pipe_auto_ack_enable      = pipe_auto_ack_enable;
		next_ack_wait_and_resend_delay = ack_wait_and_resend_delay;
		next_resend_limit              = resend_limit;
		next_resend_tally              = resend_tally;
		next_rx_ctrl_on                = rx_ctrl_on;
		next_mult                      = mult;
		next_auto_mode                 = auto_mode;
		next_last_pid                  = last_pid;
		next_last_crc                  = last_crc;
		next_last_seen                 = last_seen;
		next_rx_settle                 = rx_settle;
		next_rdata                     = 8'h00;
		next_tx_start                  = 1'b0;
		next_tx_ok                     = 1'b0;
		next_tx_fail                   = 1'b0;
		next_rx_irq                    = 1'b0;
		next_ack_send                  = 1'b0;
		tm_load                        = 1'b0;
		tm_count                       = 32'h0000_0001;

		// Register writes and reads
		if (I_REG.wr) begin
			case (I_REG.addr)
				arc_pkg::REG_MAIN_CTRL:   next_rx_ctrl_on = I_REG.wdata[arc_pkg::MAIN_RX_ON_BIT];
				arc_pkg::REG_PIPE_AA:     next_pipe_auto_ack_enable = I_REG.wdata;
				arc_pkg::REG_WAIT_RESEND: next_ack_wait_and_resend_delay = I_REG.wdata;
				arc_pkg::REG_RESEND:      next_resend_limit =
					I_REG.wdata[arc_pkg::LIMIT_MSB:arc_pkg::LIMIT_LSB];
				default: ;
			endcase
		end
		if (I_REG.rd) begin
			case (I_REG.addr)
				arc_pkg::REG_MAIN_CTRL:   next_rdata = {rx_ctrl_on, 7'h00};
				arc_pkg::REG_PIPE_AA:     next_rdata = pipe_auto_ack_enable;
				arc_pkg::REG_WAIT_RESEND: next_rdata = ack_wait_and_resend_delay;
				arc_pkg::REG_RESEND:      next_rdata = {resend_limit, resend_tally};
				default:                  next_rdata = 8'h00;
			endcase
		end

		// Transmit sequence
		case (st)
			arc_pkg::ST_IDLE: begin
				if (I_TX_CMD) begin
					next_auto_mode    = !I_TX_FIRST_BYTE[arc_pkg::NO_AUTO_BIT] &&
						pipe_enabled(pipe_auto_ack_enable, I_TX_PIPE);
					next_resend_tally = 4'h0;
					next_mult         = arc_pkg::MULT_FIRST;
					tm_load           = 1'b1;
					tm_count          = 32'(PLL_CYC);
					next_st           = arc_pkg::ST_SETTLE;
				end
			end
			arc_pkg::ST_SETTLE: begin
				if (tm_done) begin
					next_tx_start = 1'b1;
					next_st       = arc_pkg::ST_ON_AIR;
				end
			end
			arc_pkg::ST_ON_AIR: begin
				// Airtime is set by the baseband from the packet length
				if (I_TX_DONE) begin
					if (auto_mode) begin
						tm_load  = 1'b1;
						tm_count = cyc(wait_field, ACK_STEP_CYC) + 32'(ACK_STEP_CYC);
						next_st  = arc_pkg::ST_ACK_WAIT;
					end else begin
						next_tx_ok = 1'b1;
						next_st    = arc_pkg::ST_IDLE;
					end
				end
			end
			arc_pkg::ST_ACK_WAIT: begin
				if (I_ACK_OK) begin
					next_tx_ok = 1'b1;
					next_st    = arc_pkg::ST_IDLE;
				end else if (tm_done) begin
					if (resend_tally == resend_limit) begin
						next_tx_fail = 1'b1;
						next_st      = arc_pkg::ST_IDLE;
					end else if (gap_field == 4'h0) begin
						next_resend_tally = resend_tally + 4'h1;
						tm_load           = 1'b1;
						tm_count          = 32'(PLL_CYC);
						next_st           = arc_pkg::ST_SETTLE;
					end else begin
						tm_load  = 1'b1;
						tm_count = cyc(gap_field, GAP_STEP_CYC) * 32'(mult);
						next_st  = arc_pkg::ST_GAP;
					end
					next_mult = (mult == arc_pkg::MULT_LAST) ? arc_pkg::MULT_FIRST
						: mult + 2'h1;
				end
			end
			arc_pkg::ST_GAP: begin
				if (tm_done) begin
					next_resend_tally = resend_tally + 4'h1;
					tm_load           = 1'b1;
					tm_count          = 32'(PLL_CYC);
					next_st           = arc_pkg::ST_SETTLE;
				end
			end
			default: next_st = arc_pkg::ST_IDLE;
		endcase

		// Receive synthesizer and settle
		next_rx_pll_on = I_MODE || rx_ctrl_on || next_st == arc_pkg::ST_ACK_WAIT;
		if (!next_rx_pll_on) begin
			next_rx_settle = 32'h0;
		end else if (rx_settle != 32'(PLL_CYC)) begin
			next_rx_settle = rx_settle + 32'h1;
		end
		next_rx_ready = next_rx_pll_on && (next_rx_settle == 32'(PLL_CYC));

		// Received data packets
		if (I_RX_VALID) begin
			next_ack_send = pipe_enabled(pipe_auto_ack_enable, I_RX_PKT.pipe);
			if (!(last_seen && last_pid == I_RX_PKT.pid && last_crc == I_RX_PKT.crc)) begin
				next_rx_irq = 1'b1;
			end
			next_last_seen = 1'b1;
			next_last_pid  = I_RX_PKT.pid;
			next_last_crc  = I_RX_PKT.crc;
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			st                        <= arc_pkg::ST_IDLE;
			pipe_auto_ack_enable      <= arc_pkg::PIPE_AA_RST;
			ack_wait_and_resend_delay <= arc_pkg::WAIT_RESEND_RST;
			resend_limit              <= arc_pkg::LIMIT_RST;
			resend_tally              <= 4'h0;
			rx_ctrl_on                <= 1'b0;
			mult                      <= arc_pkg::MULT_FIRST;
			auto_mode                 <= 1'b0;
			last_pid                  <= 3'h0;
			last_crc                  <= 16'h0000;
			last_seen                 <= 1'b0;
			rx_settle                 <= 32'h0;
			O_REG_RDATA               <= 8'h00;
			O_TX_PLL_ON               <= 1'b0;
			O_TX_START                <= 1'b0;
			O_TX_HOLD                 <= 1'b0;
			O_RX_PLL_ON               <= 1'b0;
			O_RX_READY                <= 1'b0;
			O_ACK_SEND                <= 1'b0;
			O_TX_OK                   <= 1'b0;
			O_TX_FAIL                 <= 1'b0;
			O_RX_IRQ                  <= 1'b0;
		end else begin
			st                        <= next_st;
			pipe_auto_ack_enable      <= next_pipe_auto_ack_enable;
			ack_wait_and_resend_delay <= next_ack_wait_and_resend_delay;
			resend_limit              <= next_resend_limit;
			resend_tally              <= next_resend_tally;
			rx_ctrl_on                <= next_rx_ctrl_on;
			mult                      <= next_mult;
			auto_mode                 <= next_auto_mode;
			last_pid                  <= next_last_pid;
			last_crc                  <= next_last_crc;
			last_seen                 <= next_last_seen;
			rx_settle                 <= next_rx_settle;
			O_REG_RDATA               <= next_rdata;
			O_TX_PLL_ON               <= next_st == arc_pkg::ST_SETTLE ||
				next_st == arc_pkg::ST_ON_AIR;
			O_TX_START                <= next_tx_start;
			O_TX_HOLD                 <= next_st != arc_pkg::ST_IDLE;
			O_RX_PLL_ON               <= next_rx_pll_on;
			O_RX_READY                <= next_rx_ready;
			O_ACK_SEND                <= next_ack_send;
			O_TX_OK                   <= next_tx_ok;
			O_TX_FAIL                 <= next_tx_fail;
			O_RX_IRQ                  <= next_rx_irq;
		end
	end

endmodule : arc_ctrl

// ===== design/arc_pkg.sv
// Constants and carrier types for the auto-retransmit controller.
// Assumes a 100 MHz core clock and an SPI decoder that presents register accesses.
package arc_pkg;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0] REG_MAIN_CTRL   = 8'h00;
	localparam logic [7:0] REG_PIPE_AA     = 8'h05;
	localparam logic [7:0] REG_WAIT_RESEND = 8'h07;
	localparam logic [7:0] REG_RESEND      = 8'h08;

	// ----------------------------------------
	// Field positions and reset values
	// ----------------------------------------
	localparam int         MAIN_RX_ON_BIT  = 7;
	localparam int         WAIT_MSB        = 7;
	localparam int         WAIT_LSB        = 4;
	localparam int         GAP_MSB         = 3;
	localparam int         GAP_LSB         = 0;
	localparam int         LIMIT_MSB       = 7;
	localparam int         LIMIT_LSB       = 4;
	localparam int         NO_AUTO_BIT     = 7;
	localparam logic [7:0] PIPE_AA_RST     = 8'h00;
	localparam logic [7:0] WAIT_RESEND_RST = 8'h00;
	localparam logic [3:0] LIMIT_RST       = 4'h0;
	localparam logic [1:0] MULT_FIRST      = 2'h1;
	localparam logic [1:0] MULT_LAST       = 2'h3;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_MHZ       = 100;
	localparam int ACK_STEP_US   = 250;
	localparam int PLL_SETTLE_US = 130;
	localparam int GAP_STEP_US   = 250;
	localparam int ACK_STEP_CYC  = ACK_STEP_US * CLK_MHZ;
	localparam int PLL_CYC       = PLL_SETTLE_US * CLK_MHZ;
	localparam int GAP_STEP_CYC  = GAP_STEP_US * CLK_MHZ;

	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} arc_reg_req_s;

	typedef struct packed {
		logic [3:0]  pipe;
		logic [2:0]  pid;
		logic [15:0] crc;
	} arc_rx_pkt_s;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_SETTLE,
		ST_ON_AIR,
		ST_ACK_WAIT,
		ST_GAP
	} arc_state_e;

endpackage : arc_pkg

// ===== design/arc_timer.sv
// Loadable down-counter that pulses once when the loaded count has elapsed.
// Assumes the caller loads a count of at least one.
`timescale 1ns/1ps
module arc_timer #(
	parameter int W = 32
) (
	// Clock and reset
	input  wire logic         i_clk,
	input  wire logic         i_rst_b,
	// Control
	input  wire logic         i_load,
	input  wire logic [W-1:0] i_count,
	input  wire logic         i_stop,
	// Status
	output logic              o_done
);

	logic [W-1:0] cnt;
	logic [W-1:0] next_cnt;
	logic         next_done;

	always_comb begin
		next_cnt  = cnt;
		next_done = 1'b0;
		if (i_stop) begin
			next_cnt = '0;
		end else if (i_load) begin
			next_cnt = i_count;
		end else if (cnt != '0) begin
			next_cnt  = cnt - 1'b1;
			next_done = (cnt == {{(W-1){1'b0}}, 1'b1});
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cnt    <= '0;
			o_done <= 1'b0;
		end else begin
			cnt    <= next_cnt;
			o_done <= next_done;
		end
	end

endmodule : arc_timer

// ===== test/arc_bb_model.sv
// Peer-radio stand-in: airtime after each start, then an optional acknowledgement.
// Assumes start arrives as a one-cycle pulse.
`timescale 1ns/1ps
module arc_bb_model #(
	parameter int AIR = 6
) (
	// Clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_rst_b,
	// Controller side
	input  wire logic       i_start,
	input  wire logic       i_rx_on,
	input  wire logic       i_ack_en,
	input  wire logic [7:0] i_ack_dly,
	output logic            o_done,
	output logic            o_ack
);
	int air = 0;
	int ack = 0;
	always @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			air = 0;
			ack = 0;
			o_done <= 1'b0;
			o_ack <= 1'b0;
		end else begin
			o_done <= (air == 1);
			o_ack <= (ack == 1) && i_rx_on;
			air = i_start ? AIR : (air > 0 ? air - 1 : 0);
			ack = (o_done && i_ack_en) ? int'(i_ack_dly) : (ack > 0 ? ack - 1 : 0);
		end
	end
endmodule : arc_bb_model

// ===== test/arc_ctrl_properties.sv
// Port-level assertions for the auto-retransmit controller.
// Assumes it is bound to arc_ctrl and that the mode pin stays low while packets are sent.
`timescale 1ns/1ps
module arc_ctrl_properties #(
	parameter int ACK_STEP_CYC = 20,
	parameter int PLL_CYC      = 10,
	parameter int GAP_STEP_CYC = 5
) (
	// Watched ports
	input wire logic                  I_CLK,
	input wire logic                  I_RST_B,
	input wire arc_pkg::arc_reg_req_s I_REG,
	input wire logic [7:0]            O_REG_RDATA,
	input wire logic                  I_TX_CMD,
	input wire logic                  O_TX_PLL_ON,
	input wire logic                  O_TX_START,
	input wire logic                  O_TX_HOLD,
	input wire logic                  I_MODE,
	input wire logic                  O_RX_PLL_ON,
	input wire logic                  I_ACK_OK,
	input wire logic                  I_RX_VALID,
	input wire logic                  O_ACK_SEND,
	input wire logic                  O_TX_OK,
	input wire logic                  O_TX_FAIL,
	input wire logic                  O_RX_IRQ
);
	localparam int ST_DLY = PLL_CYC + 2;
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_RST_B);
	sequence s_cmd;
		I_TX_CMD && !O_TX_HOLD;
	endsequence
	sequence s_settle;
		O_TX_PLL_ON && O_TX_HOLD && !O_TX_START;
	endsequence
	a_settle_before_air: assert property (s_cmd |=> s_settle [*8])
		else $error("transmit started before settling");
	a_start_after_pll: assert property (s_cmd |-> ##ST_DLY O_TX_START)
		else $error("transmit start late or missing");
	a_ok_on_ack: assert property ((I_ACK_OK && O_RX_PLL_ON && O_TX_HOLD &&
		!O_TX_PLL_ON && !I_MODE) |=> O_TX_OK)
		else $error("acknowledgement gave no success pulse");
	a_hold_till_end: assert property ($fell(O_TX_HOLD) |-> (O_TX_OK || O_TX_FAIL
		|| $past(O_TX_OK) || $past(O_TX_FAIL)))
		else $error("packet released without outcome");
	a_rx_on_mode: assert property (I_MODE |=> O_RX_PLL_ON)
		else $error("mode pin did not start receive synthesizer");
	a_reply_cause: assert property ((O_RX_IRQ || O_ACK_SEND) |-> $past(I_RX_VALID))
		else $error("receive event without packet");
	a_rdata_idle: assert property (!$past(I_REG.rd) |-> O_REG_RDATA == 8'h00)
		else $error("read data outside read answer");
	a_fail_stops: assert property (O_TX_FAIL |=> (!O_TX_START && !O_TX_PLL_ON) [*4])
		else $error("resend after failure");
endmodule : arc_ctrl_properties

bind arc_ctrl arc_ctrl_properties #(.ACK_STEP_CYC(ACK_STEP_CYC), .PLL_CYC(PLL_CYC),
	.GAP_STEP_CYC(GAP_STEP_CYC)) arc_ctrl_properties_i (.I_CLK(I_CLK), .I_RST_B(I_RST_B),
	.I_REG(I_REG), .O_REG_RDATA(O_REG_RDATA), .I_TX_CMD(I_TX_CMD), .O_TX_PLL_ON(O_TX_PLL_ON),
	.O_TX_START(O_TX_START), .O_TX_HOLD(O_TX_HOLD), .I_MODE(I_MODE), .O_RX_PLL_ON(O_RX_PLL_ON),
	.I_ACK_OK(I_ACK_OK), .I_RX_VALID(I_RX_VALID), .O_ACK_SEND(O_ACK_SEND), .O_TX_OK(O_TX_OK),
	.O_TX_FAIL(O_TX_FAIL), .O_RX_IRQ(O_RX_IRQ));

// ===== test/tb_top.sv
// Self-checking bench for arc_ctrl with the peer-radio stand-in.
// Assumes short timing parameters: step 20, settle 10, gap step 5 cycles.
`timescale 1ns/1ps
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin n_mismatch++; \
	$display("ERROR %s expected %0h seen %0h", n, e, a); end end
module tb_top;
	logic clk = 0, rst_b = 0, tx_cmd = 0, mode = 0, rx_valid = 0, ack_en = 0;
	logic tx_done, ack_ok, tx_pll_on, tx_start, tx_hold, rx_pll_on, rx_ready;
	logic ack_send, tx_ok, tx_fail, rx_irq, rd_q = 0, val_q = 0;
	logic [3:0] tx_pipe = 0;
	logic [7:0] first = 0, rdata, ack_dly = 8'h03, e;
	logic [31:0] lfsr = 32'hEB077D1A;
	arc_pkg::arc_reg_req_s req = '0;
	arc_pkg::arc_rx_pkt_s pkt = '0;
	logic [7:0] expq[$];
	int gaps[$];
	int n_mismatch = 0, checks = 0, cyc = 0, t0 = 0, rxon = 0;
	arc_ctrl #(.ACK_STEP_CYC(20), .PLL_CYC(10), .GAP_STEP_CYC(5)) arc_ctrl_i (
		.I_CLK(clk), .I_RST_B(rst_b), .I_REG(req), .O_REG_RDATA(rdata), .I_TX_CMD(tx_cmd),
		.I_TX_PIPE(tx_pipe), .I_TX_FIRST_BYTE(first), .O_TX_PLL_ON(tx_pll_on),
		.O_TX_START(tx_start), .I_TX_DONE(tx_done), .O_TX_HOLD(tx_hold), .I_MODE(mode),
		.O_RX_PLL_ON(rx_pll_on), .O_RX_READY(rx_ready), .I_ACK_OK(ack_ok),
		.I_RX_VALID(rx_valid), .I_RX_PKT(pkt), .O_ACK_SEND(ack_send), .O_TX_OK(tx_ok),
		.O_TX_FAIL(tx_fail), .O_RX_IRQ(rx_irq));
	arc_bb_model arc_bb_model_i (.i_clk(clk), .i_rst_b(rst_b), .i_start(tx_start),
		.i_rx_on(rx_pll_on), .i_ack_en(ack_en), .i_ack_dly(ack_dly), .o_done(tx_done),
		.o_ack(ack_ok));
	initial forever #5 clk = ~clk;
	// ----
	// Watchers
	// ----
	always @(posedge clk) begin
		cyc++;
		if (tx_done) t0 = cyc;
		if (rx_pll_on) rxon++;
		if (tx_start && t0 > 0) gaps.push_back(cyc - t0);
		rd_q <= req.rd;
		val_q <= rx_valid;
		if (rd_q || val_q || tx_ok || tx_fail) begin
			e = expq.size() ? expq.pop_front() : 8'hEE;
			`CHK("result", e, rd_q ? rdata : {4'h0, rx_irq, ack_send, tx_ok, tx_fail})
		end
		if (cyc == 20000) begin
			n_mismatch++;
			test_done();
		end
	end
	// ----
	// Drivers
	// ----
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		req <= '{1'b1, 1'b0, a, d};
		@(posedge clk);
		req <= '0;
		@(posedge clk);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] x);
		expq.push_back(x);
		req <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge clk);
		req <= '0;
		repeat (2) @(posedge clk);
	endtask : rd
	task automatic send(input logic [3:0] p, input logic [7:0] b, input logic ok);
		expq.push_back(ok ? 8'h02 : 8'h01);
		tx_pipe <= p;
		first <= b;
		tx_cmd <= 1'b1;
		@(posedge clk);
		tx_cmd <= 1'b0;
		for (int i = 0; i < 3000 && !(tx_ok || tx_fail); i++) @(posedge clk);
		repeat (6) @(posedge clk);
	endtask : send
	task automatic rx(input logic [3:0] p, input logic [2:0] i, input logic [7:0] x);
		expq.push_back(x);
		pkt <= '{p, i, 16'hA5C3};
		rx_valid <= 1'b1;
		@(posedge clk);
		rx_valid <= 1'b0;
		repeat (2) @(posedge clk);
	endtask : rx
	task automatic test_done();
		if (n_mismatch == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : test_done
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr_next
	initial begin
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		for (int i = 0; i <= 8; i++) rd(8'(i), 8'h00);
		lfsr = lfsr_next(lfsr);
		wr(8'h05, lfsr[7:0]);
		rd(8'h05, lfsr[7:0]);
		wr(8'h08, 8'hFF);
		rd(8'h08, 8'hF0);
		wr(8'h00, 8'hFF);
		rd(8'h00, 8'h80);
		wr(8'h00, 8'h00);
		wr(8'h05, 8'hFB);
		wr(8'h07, 8'h00);
		send(4'h1, 8'h80, 1'b1);
		send(4'h3, 8'h00, 1'b1);
		ack_en <= 1'b1;
		send(4'h2, 8'h00, 1'b1);
		ack_dly <= 8'h0F;
		send(4'h2, 8'h00, 1'b1);
		ack_en <= 1'b0;
		wr(8'h07, 8'h13);
		wr(8'h08, 8'h40);
		gaps.delete();
		t0 = 0;
		rxon = 0;
		send(4'h1, 8'h00, 1'b0);
		rd(8'h08, 8'h44);
		`CHK("resends", 4, gaps.size())
		`CHK("first gap", 1'b1, gaps[0] >= 67 && gaps[0] <= 70)
		`CHK("gap two", 15, gaps[1] - gaps[0])
		`CHK("gap three", 30, gaps[2] - gaps[0])
		`CHK("gap four", gaps[0], gaps[3])
		`CHK("rx window", 1'b1, rxon >= 200 && rxon <= 205)
		rx(4'h1, 3'h1, 8'h0C);
		rx(4'h1, 3'h1, 8'h04);
		rx(4'h3, 3'h2, 8'h08);
		mode <= 1'b1;
		repeat (15) @(posedge clk);
		`CHK("rx ready", 1'b1, rx_ready)
		mode <= 1'b0;
		repeat (5) @(posedge clk);
		`CHK("queue left", 0, expq.size())
		test_done();
	end
endmodule : tb_top
